// ===== rtl/dsc_start_ctrl.sv
`timescale 1ns/1ps
// Summary of operation
// RULE1 - start flags for counters L, K, J, I, H are bits 11, 10, 9, 8, 7
// RULE2 - flag low holds counter, flag high decrements it; flags reset low
// RULE3 - a counter underflow clears its own start flag
// RULE4 - channel 2 general matches A..D clear flags I, J, K, L
// RULE5 - flag H clears on channel 1 general H match, out-compare match or underflow
// RULE6 - plain mode: only a software write sets a flag, and only if count nonzero
// RULE7 - offset mode: channel 2 out-compare A..D set I..L if nonzero or reloadable
// RULE8 - offset mode: software write also sets a flag when count nonzero
// RULE9 - offset mode: channel 1 out-compare or general H match sets flag H; those matches also clear H and the clear wins, so they never set it
// RULE10 - underflow forces the counter value to zero
// RULE11 - reload enabled and reload value nonzero: reload on set event, then set flag; code reloads only on channel 2 out-compare sets
// RULE12 - start register clears on reset and on standby entry
// RULE13 - a clearing event beats a setting event in the same cycle; a software clear write loses to a hardware set
module dsc_start_ctrl
    import dsc_pkg::*;
(
    input wire logic ref_clk,
    input wire logic resetn,
    input wire dsc_axi_req_t axiReq,
    output dsc_axi_rsp_t axiRsp,
    input wire dsc_match_t matchIn,
    input wire logic [NCNT-1:0] countTick,
    input wire logic standby,
    output logic [NCNT-1:0] startFlags,
    output logic [NCNT-1:0] underflowPulse
);
    typedef struct packed {
        logic [NCNT-1:0] flags;
        logic [NCNT-1:0] mode;
        logic [NCNT-1:0] rlden;
        logic [NCNT-1:0][CNT_W-1:0] reload;
        logic [NCNT-1:0] uflow;
        logic awHave;
        logic [ADDR_W-1:0] awAddr;
        logic wHave;
        logic [31:0] wData;
        logic [3:0] wStrb;
        dsc_axi_rsp_t rsp;
    } dsc_state_t;

    dsc_state_t s_q;
    dsc_state_t s_d;

    logic [NCNT-1:0][CNT_W-1:0] countW;
    logic [NCNT-1:0] uflowW;
    logic [NCNT-1:0] loadEn;
    logic [NCNT-1:0][CNT_W-1:0] loadVal;
    logic [NCNT-1:0] reloadEn;
    logic [NCNT-1:0] setEv;
    logic [NCNT-1:0] clrEv;

    // ****************************************
    // helpers
    // ****************************************
    function automatic logic inBank(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] base);
        inBank = (a[ADDR_W-1:2] >= base[ADDR_W-1:2])
            && (a[ADDR_W-1:2] < base[ADDR_W-1:2] + 6'(NCNT));
    endfunction : inBank

    function automatic logic [2:0] bankIdx(input logic [ADDR_W-1:0] a,
        input logic [ADDR_W-1:0] base);
        logic [5:0] d;
        d = a[ADDR_W-1:2] - base[ADDR_W-1:2];
        bankIdx = d[2:0];
    endfunction : bankIdx

    function automatic logic [31:0] placeFlags(input logic [NCNT-1:0] f);
        logic [31:0] r;
        r = DATA_ZERO;
        r[FLAG_LSB +: NCNT] = f; // RULE1
        placeFlags = r;
    endfunction : placeFlags

    // ****************************************
    // counters
    // ****************************************
    genvar gi;
    generate
        for (gi = 0; gi < NCNT; gi++) begin : g_cnt
            dsc_down_counter u_cnt (
                .ref_clk(ref_clk),
                .resetn(resetn),
                .run(s_q.flags[gi]), // RULE2
                .tick(countTick[gi]),
                .loadEn(loadEn[gi]),
                .loadVal(loadVal[gi]),
                .reloadEn(reloadEn[gi]),
                .reloadVal(s_q.reload[gi]),
                .count(countW[gi]),
                .underflow(uflowW[gi])
            );
        end
    endgenerate

    assign axiRsp = s_q.rsp;
    assign startFlags = s_q.flags;
    assign underflowPulse = s_q.uflow;

    // ****************************************
    // next state
    // ****************************************
    always_comb begin
        logic [31:0] m;
        logic [NCNT-1:0] swSet;
        logic [NCNT-1:0] swClr;
        logic [NCNT-1:0] hwSet;
        logic wrDo;
        logic hit;
        logic [2:0] k;
        m = DATA_ZERO;
        swSet = '0;
        swClr = '0;
        hwSet = '0;
        hit = 1'b0;
        wrDo = 1'b0;
        k = 3'h0;
        s_d = s_q;
        loadEn = '0;
        loadVal = countW;
        reloadEn = '0;
        setEv = '0;
        clrEv = '0;

        // write address and data, either order
        if (axiReq.awvalid && s_q.rsp.awready) begin
            s_d.awHave = 1'b1;
            s_d.awAddr = axiReq.awaddr;
        end
        if (axiReq.wvalid && s_q.rsp.wready) begin
            s_d.wHave = 1'b1;
            s_d.wData = axiReq.wdata;
            s_d.wStrb = axiReq.wstrb;
        end
        if (s_q.rsp.bvalid && axiReq.bready) begin
            s_d.rsp.bvalid = 1'b0;
        end
        wrDo = s_q.awHave && s_q.wHave && !s_q.rsp.bvalid;
        for (int b = 0; b < 4; b++) begin
            m[b*8 +: 8] = {8{s_q.wStrb[b]}};
        end
        if (wrDo) begin
            s_d.awHave = 1'b0;
            s_d.wHave = 1'b0;
            s_d.rsp.bvalid = 1'b1;
            s_d.rsp.bresp = RESP_OKAY;
            if (s_q.awAddr == OFF_START) begin
                for (int i = 0; i < NCNT; i++) begin
                    if (m[FLAG_LSB+i]) begin
                        // RULE6 RULE8
                        swSet[i] = s_q.wData[FLAG_LSB+i] && (countW[i] != CNT_ZERO);
                        swClr[i] = !s_q.wData[FLAG_LSB+i];
                    end
                end
            end else if (s_q.awAddr == OFF_MODE) begin
                s_d.mode = (s_q.mode & ~m[FLAG_LSB +: NCNT])
                    | (s_q.wData[FLAG_LSB +: NCNT] & m[FLAG_LSB +: NCNT]);
            end else if (s_q.awAddr == OFF_RLDEN) begin
                s_d.rlden = (s_q.rlden & ~m[FLAG_LSB +: NCNT])
                    | (s_q.wData[FLAG_LSB +: NCNT] & m[FLAG_LSB +: NCNT]);
            end else if (inBank(s_q.awAddr, OFF_COUNT0)) begin
                k = bankIdx(s_q.awAddr, OFF_COUNT0);
                loadEn[k] = 1'b1;
                loadVal[k] = (countW[k] & ~m[CNT_W-1:0]) | (s_q.wData[CNT_W-1:0] & m[CNT_W-1:0]);
            end else if (inBank(s_q.awAddr, OFF_RELOAD0)) begin
                k = bankIdx(s_q.awAddr, OFF_RELOAD0);
                s_d.reload[k] = (s_q.reload[k] & ~m[CNT_W-1:0])
                    | (s_q.wData[CNT_W-1:0] & m[CNT_W-1:0]);
            end else begin
                s_d.rsp.bresp = RESP_SLVERR;
            end
        end

        // read channel
        if (s_q.rsp.rvalid && axiReq.rready) begin
            s_d.rsp.rvalid = 1'b0;
        end
        if (axiReq.arvalid && s_q.rsp.arready) begin
            s_d.rsp.rvalid = 1'b1;
            s_d.rsp.rresp = RESP_OKAY;
            s_d.rsp.rdata = DATA_ZERO;
            hit = 1'b1;
            if (axiReq.araddr == OFF_START) begin
                s_d.rsp.rdata = placeFlags(s_q.flags);
            end else if (axiReq.araddr == OFF_MODE) begin
                s_d.rsp.rdata = placeFlags(s_q.mode);
            end else if (axiReq.araddr == OFF_RLDEN) begin
                s_d.rsp.rdata = placeFlags(s_q.rlden);
            end else if (inBank(axiReq.araddr, OFF_COUNT0)) begin
                s_d.rsp.rdata[CNT_W-1:0] = countW[bankIdx(axiReq.araddr, OFF_COUNT0)];
            end else if (inBank(axiReq.araddr, OFF_RELOAD0)) begin
                s_d.rsp.rdata[CNT_W-1:0] = s_q.reload[bankIdx(axiReq.araddr, OFF_RELOAD0)];
            end else begin
                hit = 1'b0;
            end
            if (!hit) begin
                s_d.rsp.rresp = RESP_SLVERR;
            end
        end

        // hardware set and clear events
        hwSet[IDX_H] = s_q.mode[IDX_H] && (countW[IDX_H] != CNT_ZERO)
            && (matchIn.ch1OutCompareMatch || matchIn.ch1GeneralHMatch); // RULE9
        clrEv[IDX_H] = uflowW[IDX_H] || matchIn.ch1GeneralHMatch
            || matchIn.ch1OutCompareMatch; // RULE5
        for (int i = 1; i < NCNT; i++) begin
            if (s_q.mode[i] && matchIn.ch2OutCompareMatch[i-1]) begin
                // RULE11
                reloadEn[i] = s_q.rlden[i] && (s_q.reload[i] != CNT_ZERO);
                hwSet[i] = (countW[i] != CNT_ZERO) || reloadEn[i]; // RULE7
            end
            clrEv[i] = uflowW[i] || matchIn.ch2GeneralMatch[i-1]; // RULE3 RULE4
        end
        setEv = swSet | hwSet;
        for (int i = 0; i < NCNT; i++) begin
            if (standby) begin
                s_d.flags[i] = 1'b0; // RULE12
            end else if (clrEv[i]) begin
                s_d.flags[i] = 1'b0; // RULE13
            end else if (setEv[i]) begin
                s_d.flags[i] = 1'b1;
            end else if (swClr[i]) begin
                s_d.flags[i] = 1'b0;
            end
        end
        s_d.uflow = uflowW;

        s_d.rsp.awready = !s_d.awHave && !s_d.rsp.bvalid;
        s_d.rsp.wready = !s_d.wHave && !s_d.rsp.bvalid;
        s_d.rsp.arready = !s_d.rsp.rvalid;
    end

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            s_q <= '0; // RULE12
        end else begin
            s_q <= s_d;
        end
    end

    // ****************************************
    // checks
    // ****************************************
    logic [NCNT-1:0] swSetMask;
    logic [NCNT-1:0] swSet_dbg;
    assign swSetMask = {NCNT{s_q.awHave && s_q.wHave && !s_q.rsp.bvalid
        && s_q.awAddr == OFF_START}};
    assign swSet_dbg = setEv & ~clrEv & swSetMask;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);

    uflow_clear_a: assert property ((s_q.flags & $past(uflowW)) == FLAGS_RST) // RULE3
        else $error("flag survived underflow");
    ch2_clear_a: assert property ((s_q.flags[4:1] & $past(matchIn.ch2GeneralMatch)) == 4'h0) // RULE4
        else $error("flag survived channel 2 general match");
    h_clear_a: assert property ($past(matchIn.ch1GeneralHMatch || matchIn.ch1OutCompareMatch)
        |-> !s_q.flags[IDX_H]) // RULE5 RULE13
        else $error("flag h survived channel 1 match");
    standby_clear_a: assert property ($past(standby) |-> s_q.flags == FLAGS_RST) // RULE12
        else $error("flags not cleared by standby");
    plain_set_a: assert property ((s_q.flags & ~$past(s_q.flags) & ~$past(s_q.mode)
        & ~$past(swSet_dbg)) == FLAGS_RST) // RULE6
        else $error("flag set without software in plain mode");
    reload_set_a: assert property (reloadEn[2] && !loadEn[2] && !clrEv[2] && !standby
        |=> s_q.flags[2] && countW[2] == $past(s_q.reload[2])) // RULE11
        else $error("reload did not load and start");
    wr_resp_a: assert property (s_q.awHave && s_q.wHave && !s_q.rsp.bvalid
        |=> s_q.rsp.bvalid && !s_q.awHave) // write answered one cycle after address and data
        else $error("write not answered next cycle");
    flag_pos_a: assert property (s_q.rsp.rvalid && $past(axiReq.araddr == OFF_START
        && axiReq.arvalid && s_q.rsp.arready) |-> s_q.rsp.rdata[FLAG_LSB +: NCNT]
        == $past(s_q.flags)) // RULE1
        else $error("start flags misplaced in read data");
endmodule : dsc_start_ctrl

// ===== rtl/dsc_pkg.sv
package dsc_pkg;
    // ****************************************
    // sizes and positions
    // ****************************************
    localparam int NCNT = 5;
    localparam int CNT_W = 16;
    localparam int FLAG_LSB = 7;
    localparam int IDX_H = 0;
    localparam int ADDR_W = 8;
    localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
    localparam logic [NCNT-1:0] FLAGS_RST = 5'h00;
    localparam logic [31:0] DATA_ZERO = 32'h00000000;

    // ****************************************
    // register offsets
    // ****************************************
    localparam logic [ADDR_W-1:0] OFF_START = 8'h00;
    localparam logic [ADDR_W-1:0] OFF_MODE = 8'h04;
    localparam logic [ADDR_W-1:0] OFF_RLDEN = 8'h08;
    localparam logic [ADDR_W-1:0] OFF_COUNT0 = 8'h10;
    localparam logic [ADDR_W-1:0] OFF_RELOAD0 = 8'h30;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ****************************************
    // carriers
    // ****************************************
    typedef struct packed {
        logic awvalid;
        logic [ADDR_W-1:0] awaddr;
        logic wvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bready;
        logic arvalid;
        logic [ADDR_W-1:0] araddr;
        logic rready;
    } dsc_axi_req_t;

    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } dsc_axi_rsp_t;

    typedef struct packed {
        logic [3:0] ch2GeneralMatch;
        logic [3:0] ch2OutCompareMatch;
        logic ch1GeneralHMatch;
        logic ch1OutCompareMatch;
    } dsc_match_t;
endpackage : dsc_pkg

// ===== rtl/dsc_down_counter.sv
`timescale 1ns/1ps
module dsc_down_counter
    import dsc_pkg::*;
(
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic run,
    input wire logic tick,
    input wire logic loadEn,
    input wire logic [CNT_W-1:0] loadVal,
    input wire logic reloadEn,
    input wire logic [CNT_W-1:0] reloadVal,
    output logic [CNT_W-1:0] count,
    output logic underflow
);
    typedef struct packed {
        logic [CNT_W-1:0] count;
    } dsc_cnt_state_t;

    dsc_cnt_state_t s_q;
    dsc_cnt_state_t s_d;

    assign count = s_q.count;
    // decrement from zero is the underflow
    assign underflow = run && tick && (s_q.count == CNT_ZERO);

    always_comb begin
        s_d = s_q;
        if (loadEn) begin
            s_d.count = loadVal;
        end else if (reloadEn) begin
            s_d.count = reloadVal;
        end else if (underflow) begin
            s_d.count = CNT_ZERO; // RULE10
        end else if (run && tick) begin
            s_d.count = s_q.count - 16'h0001; // RULE2
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            s_q <= '{count: CNT_ZERO};
        end else begin
            s_q <= s_d;
        end
    end

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);

    count_hold_a: assert property (!run && !loadEn && !reloadEn |=> count == $past(count)) // RULE2
        else $error("stopped counter changed");
    count_dec_a: assert property (run && tick && count != CNT_ZERO && !loadEn && !reloadEn
        |=> count == $past(count) - 16'h0001) // RULE2
        else $error("running counter did not decrement");
    uflow_zero_a: assert property (underflow && !loadEn && !reloadEn |=> count == CNT_ZERO) // RULE10
        else $error("counter not zero after underflow");
endmodule : dsc_down_counter

// ===== verif/tb_down_count_start_control.sv
`timescale 1ns/1ps
module tb_down_count_start_control;
    import dsc_pkg::*;
    // ****************************************
    // signals and design
    // ****************************************
    logic ref_clk;
    logic resetn;
    dsc_axi_req_t axiReq;
    dsc_axi_rsp_t axiRsp;
    dsc_match_t matchIn;
    logic [NCNT-1:0] countTick;
    logic standby;
    logic [NCNT-1:0] startFlags;
    logic [NCNT-1:0] underflowPulse;
    logic [NCNT-1:0] ufSeen;
    logic ufClr;
    logic [31:0] rd;
    logic [1:0] rs;
    int n_fail;
    int checks;

    dsc_start_ctrl dut (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .axiReq(axiReq),
        .axiRsp(axiRsp),
        .matchIn(matchIn),
        .countTick(countTick),
        .standby(standby),
        .startFlags(startFlags),
        .underflowPulse(underflowPulse)
    );

    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end

    // sticky record of underflow pulses
    always @(posedge ref_clk) begin
        if (ufClr) begin
            ufSeen <= 5'h00;
        end else begin
            ufSeen <= ufSeen | underflowPulse;
        end
    end

    // ****************************************
    // helpers
    // ****************************************
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : wrap_up

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("[FAIL] %0t %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask : check

    task automatic stall();
        n_fail++;
        $display("[FAIL] %0t bus wait ran out", $time);
        wrap_up();
    endtask : stall

    function automatic logic [ADDR_W-1:0] at(input logic [ADDR_W-1:0] b, input int i);
        return b + ADDR_W'(4 * i);
    endfunction : at

    task automatic axi_wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
        int n;
        logic done;
        n = 0;
        done = 1'b0;
        @(posedge ref_clk);
        axiReq.awaddr <= a;
        axiReq.wdata <= d;
        axiReq.wstrb <= 4'hF;
        axiReq.awvalid <= 1'b1;
        axiReq.wvalid <= 1'b1;
        axiReq.bready <= 1'b1;
        while (!done) begin
            @(posedge ref_clk);
            n++;
            if (axiReq.awvalid && axiRsp.awready) axiReq.awvalid <= 1'b0;
            if (axiReq.wvalid && axiRsp.wready) axiReq.wvalid <= 1'b0;
            if (axiRsp.bvalid === 1'b1) begin
                rs = axiRsp.bresp;
                axiReq.bready <= 1'b0;
                done = 1'b1;
            end
            if (n > 40) stall();
        end
    endtask : axi_wr

    task automatic axi_rd(input logic [ADDR_W-1:0] a);
        int n;
        logic done;
        n = 0;
        done = 1'b0;
        @(posedge ref_clk);
        axiReq.araddr <= a;
        axiReq.arvalid <= 1'b1;
        axiReq.rready <= 1'b1;
        while (!done) begin
            @(posedge ref_clk);
            n++;
            if (axiReq.arvalid && axiRsp.arready) axiReq.arvalid <= 1'b0;
            if (axiRsp.rvalid === 1'b1) begin
                rd = axiRsp.rdata;
                rs = axiRsp.rresp;
                axiReq.rready <= 1'b0;
                done = 1'b1;
            end
            if (n > 40) stall();
        end
    endtask : axi_rd

    task automatic pulse(input dsc_match_t m);
        matchIn <= m;
        @(posedge ref_clk);
        matchIn <= 10'h000;
        @(posedge ref_clk);
    endtask : pulse

    task automatic tick(input int i);
        countTick <= 5'h01 << i;
        @(posedge ref_clk);
        countTick <= 5'h00;
        @(posedge ref_clk);
    endtask : tick

    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_reset();
        check(32'(startFlags), 32'(FLAGS_RST), "flags after reset");
        axi_rd(OFF_START);
        check(rd, DATA_ZERO, "start reg after reset");
    endtask : t_reset

    task automatic t_positions();
        for (int i = 0; i < NCNT; i++) begin
            axi_wr(at(OFF_COUNT0, i), 32'h00000001);
            axi_wr(OFF_START, 32'h00000001 << (FLAG_LSB + i));
            check(32'(startFlags), 32'h00000001 << i, "single flag");
            axi_rd(OFF_START);
            check(rd, 32'h00000001 << (FLAG_LSB + i), "start bit position");
        end
        axi_wr(OFF_START, DATA_ZERO);
    endtask : t_positions

    task automatic t_plain_run();
        ufClr <= 1'b1;
        @(posedge ref_clk);
        ufClr <= 1'b0;
        axi_wr(at(OFF_COUNT0, 4), DATA_ZERO);
        axi_wr(OFF_START, 32'h00000800);
        check(32'(startFlags), 32'h00000000, "set refused at zero");
        axi_wr(at(OFF_COUNT0, 4), 32'h00000002);
        tick(4);
        axi_rd(at(OFF_COUNT0, 4));
        check(rd, 32'h00000002, "stopped counter held");
        pulse('{ch2GeneralMatch: 4'h0, ch2OutCompareMatch: 4'h8, default: 1'b0});
        check(32'(startFlags), 32'h00000000, "plain mode ignores match");
        axi_wr(OFF_START, 32'h00000800);
        check(32'(startFlags), 32'h00000010, "software set");
        tick(4);
        tick(4);
        axi_rd(at(OFF_COUNT0, 4));
        check(rd, 32'h00000000, "counted down");
        check(32'(startFlags | ufSeen), 32'h00000010, "still running at zero");
        tick(4);
        repeat (3) @(posedge ref_clk);
        check(32'(startFlags), 32'h00000000, "underflow clears flag");
        check(32'(ufSeen), 32'h00000010, "underflow pulse");
        axi_rd(at(OFF_COUNT0, 4));
        check(rd, 32'h00000000, "count zero after underflow");
    endtask : t_plain_run

    task automatic t_match_clear();
        logic [NCNT-1:0] exp;
        for (int i = 0; i < NCNT; i++) axi_wr(at(OFF_COUNT0, i), 32'h00000009);
        axi_wr(OFF_START, 32'h00000F80);
        exp = 5'h1F;
        for (int k = 0; k < 4; k++) begin
            pulse('{ch2GeneralMatch: 4'h1 << k, ch2OutCompareMatch: 4'h0, default: 1'b0});
            exp[k + 1] = 1'b0;
            check(32'(startFlags), 32'(exp), "general match clear");
        end
        pulse('{ch2GeneralMatch: 4'h0, ch2OutCompareMatch: 4'h0, ch1GeneralHMatch: 1'b1,
            ch1OutCompareMatch: 1'b0});
        check(32'(startFlags), 32'h00000000, "general h clear");
        axi_wr(OFF_START, 32'h00000080);
        pulse('{ch2GeneralMatch: 4'h0, ch2OutCompareMatch: 4'h0, ch1GeneralHMatch: 1'b0,
            ch1OutCompareMatch: 1'b1});
        check(32'(startFlags), 32'h00000000, "out compare h clear");
    endtask : t_match_clear

    task automatic t_offset();
        axi_wr(OFF_MODE, 32'h00000F80);
        pulse('{ch2GeneralMatch: 4'h0, ch2OutCompareMatch: 4'hF, default: 1'b0});
        check(32'(startFlags), 32'h0000001E, "out compare sets");
        axi_wr(OFF_START, DATA_ZERO);
        pulse('{ch2GeneralMatch: 4'h1, ch2OutCompareMatch: 4'h1, default: 1'b0});
        check(32'(startFlags), 32'h00000000, "clear beats set");
        axi_wr(at(OFF_COUNT0, 2), DATA_ZERO);
        axi_wr(at(OFF_COUNT0, 3), DATA_ZERO);
        axi_wr(OFF_RLDEN, 32'h00000200);
        axi_wr(at(OFF_RELOAD0, 2), 32'h00000005);
        pulse('{ch2GeneralMatch: 4'h0, ch2OutCompareMatch: 4'h6, default: 1'b0});
        check(32'(startFlags), 32'h00000004, "reload set, zero refused");
        axi_rd(at(OFF_COUNT0, 2));
        check(rd, 32'h00000005, "reloaded count");
        axi_wr(OFF_START, 32'h00000E80);
        check(32'(startFlags), 32'h00000015, "offset software set");
    endtask : t_offset

    task automatic t_standby();
        standby <= 1'b1;
        @(posedge ref_clk);
        standby <= 1'b0;
        @(posedge ref_clk);
        check(32'(startFlags), 32'h00000000, "standby clears");
        axi_rd(OFF_START);
        check(rd, DATA_ZERO, "start reg after standby");
    endtask : t_standby

    task automatic t_unmapped();
        axi_wr(8'hFC, 32'hFFFFFFFF);
        check(32'(rs), 32'(RESP_SLVERR), "unmapped write");
        axi_rd(8'hFC);
        check(32'(rs), 32'(RESP_SLVERR), "unmapped read");
        check(rd, DATA_ZERO, "unmapped data");
    endtask : t_unmapped

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        resetn = 1'b0;
        axiReq = '0;
        matchIn = 10'h000;
        countTick = 5'h00;
        standby = 1'b0;
        ufClr = 1'b1;
        n_fail = 0;
        checks = 0;
        repeat (5) @(posedge ref_clk);
        resetn <= 1'b1;
        repeat (2) @(posedge ref_clk);
        t_reset();
        t_positions();
        t_plain_run();
        t_match_clear();
        t_offset();
        t_standby();
        t_unmapped();
        wrap_up();
    end
endmodule : tb_down_count_start_control
